// ---- hdl/dram_arb_pkg.sv ----
// Package with the types and constants of the dual-port DRAM arbiter.
package dram_arb_pkg;

    // Grant encoding: low means the first port owns the array.
    localparam logic GRANT_FIRST = 1'b0;
    localparam logic GRANT_SECOND = 1'b1;
    localparam logic GRANT_RST = GRANT_FIRST;

    // Grant-to-strobe delay selections, in clock edges after the grant asserts.
    localparam logic [1:0] START_EDGES_MIN = 2'h1;
    localparam logic [1:0] START_EDGES_MAX = 2'h2;

    // Depth of the synchroniser on the delay-line clock domain's refresh demand.
    localparam int SYNC_DEPTH = 3;

    // Gray-coded arbiter states for the second port's access.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_ACCESS = 2'b11,
        ST_HOLD = 2'b10
    } arb_state_t;

    // First-port request group, active high after pin inversion.
    typedef struct packed {
        logic chip_select;
        logic addr_strobe;
        logic request;
        logic lock;
    } first_port_t;

    // Strobe outputs of the second port's access.
    typedef struct packed {
        logic row_strobe;
        logic col_strobe;
        logic early_ack;
    } strobe_out_t;

endpackage

// ---- hdl/dram_dual_port_arbiter.sv ----
// Dual-port DRAM arbiter sharing one array between two ports and refresh.
// Contract
// - Refresh first, granted port next, other last.
// - Last granted port keeps grant until other requests.
// - Second port request input starts an access.
// - Granted second port strobes row on request.
// - Column strobes extend while column enables stay asserted.
// - Ungranted start: one or two edges after grant.
// - Grant moves when first idle, unlocked, second requesting.
// - Chip select with strobe or request: first request.
// - Early ack follows row strobe until request release.
// - Grant high means second port owns array.
// - Grant changes after current request negates, before strobe.
// - Lock freezes grant but never blocks refresh.
// - Ungranted or locked-out port receives wait states.
// - Access and delay clocks shared or asynchronous.
`timescale 1ns/1ns
module dram_dual_port_arbiter #(
    // Stages of the refresh-demand synchroniser.
    parameter int SYNC_STAGES = dram_arb_pkg::SYNC_DEPTH
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // First port, active high, synchronous to clk_sys.
    input wire dram_arb_pkg::first_port_t first_port,
    // Second port request, active high, decode folded in externally.
    input wire logic second_port_request,
    // Refresh demand from the delay-line clock domain.
    input wire logic refresh_demand,
    input wire logic refresh_busy,
    // Precharge still running for the bank being addressed.
    input wire logic precharge_wait,
    // Column enables and their programmed extension option.
    input wire logic column_enable_first,
    input wire logic column_enable_n,
    input wire logic cas_extend_cfg,
    // Grant delay selection: 0 for one edge, 1 for two.
    input wire logic grant_delay_cfg_low,
    input wire logic grant_delay_cfg_high,
    // Outputs.
    output logic second_port_grant,
    output logic second_port_early_ack,
    output logic row_strobe,
    output logic col_strobe,
    output logic first_port_wait,
    output logic refresh_grant
);

    typedef struct packed {
        dram_arb_pkg::arb_state_t state;
        logic grant;
        logic [1:0] start_cnt;
        dram_arb_pkg::strobe_out_t strobes;
        logic [SYNC_STAGES-1:0] ref_sync;
        logic ref_seen;
        logic ref_active;
    } arb_reg_t;

    // The level detector reads the last two stages, so fewer than three would read a metastable flop.
    if (SYNC_STAGES < 3) begin : g_sync_depth_check
        $error("refresh synchroniser needs at least three stages");
    end

    arb_reg_t cur_ff;
    arb_reg_t nxt_cur;

    logic first_req;
    logic ref_level;
    logic [1:0] start_target;
    logic col_hold;

    // Chip select qualifies either strobe or request.
    assign first_req = first_port.chip_select & (first_port.addr_strobe | first_port.request);
    // A change counts once the second and third stages agree.
    assign ref_level = cur_ff.ref_seen;
    assign start_target = grant_delay_cfg_low ? dram_arb_pkg::START_EDGES_MAX : dram_arb_pkg::START_EDGES_MIN;
    assign col_hold = cas_extend_cfg & column_enable_first & column_enable_n;

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.ref_sync = {cur_ff.ref_sync[SYNC_STAGES-2:0], refresh_demand};
        // Waiting for two agreeing stages keeps one metastable sample from starting or ending a refresh.
        if (cur_ff.ref_sync[SYNC_STAGES-1] == cur_ff.ref_sync[SYNC_STAGES-2]) begin
            nxt_cur.ref_seen = cur_ff.ref_sync[SYNC_STAGES-1];
        end
        // Refresh owns the array first, whatever the lock says.
        // It is taken only from idle, so a running access is never cut short.
        if (ref_level && cur_ff.state == dram_arb_pkg::ST_IDLE) begin
            nxt_cur.ref_active = 1'b1;
        end else if (!ref_level && !refresh_busy) begin
            nxt_cur.ref_active = 1'b0;
        end
        unique case (cur_ff.state)
            dram_arb_pkg::ST_IDLE: begin
                if (!cur_ff.ref_active && !ref_level && second_port_request) begin
                    if (cur_ff.grant == dram_arb_pkg::GRANT_SECOND) begin
                        if (!precharge_wait && !refresh_busy) begin
                            nxt_cur.state = dram_arb_pkg::ST_ACCESS;
                            nxt_cur.strobes = '{row_strobe: 1'b1, col_strobe: 1'b1, early_ack: 1'b1};
                        end
                    end else if (!first_req && !first_port.lock) begin
                        nxt_cur.grant = dram_arb_pkg::GRANT_SECOND;
                        nxt_cur.start_cnt = dram_arb_pkg::START_EDGES_MIN;
                        nxt_cur.state = dram_arb_pkg::ST_WAIT;
                    end
                end else if (first_req && !second_port_request && !first_port.lock
                             && cur_ff.grant == dram_arb_pkg::GRANT_SECOND) begin
                    // The grant returns only on a request from the other port.
                    nxt_cur.grant = dram_arb_pkg::GRANT_FIRST;
                end
            end
            dram_arb_pkg::ST_WAIT: begin
                if (!second_port_request) begin
                    nxt_cur.state = dram_arb_pkg::ST_IDLE;
                end else if (cur_ff.start_cnt >= start_target && !precharge_wait && !first_req) begin
                    nxt_cur.state = dram_arb_pkg::ST_ACCESS;
                    nxt_cur.strobes = '{row_strobe: 1'b1, col_strobe: 1'b1, early_ack: 1'b1};
                end else if (cur_ff.start_cnt < start_target) begin
                    nxt_cur.start_cnt = cur_ff.start_cnt + 2'h1;
                end
            end
            dram_arb_pkg::ST_ACCESS: begin
                if (!second_port_request) begin
                    // Release drops row strobe and the early acknowledge.
                    nxt_cur.strobes.row_strobe = 1'b0;
                    nxt_cur.strobes.early_ack = 1'b0;
                    nxt_cur.strobes.col_strobe = col_hold;
                    nxt_cur.state = col_hold ? dram_arb_pkg::ST_HOLD : dram_arb_pkg::ST_IDLE;
                end
            end
            dram_arb_pkg::ST_HOLD: begin
                if (!col_hold) begin
                    nxt_cur.strobes.col_strobe = 1'b0;
                    nxt_cur.state = dram_arb_pkg::ST_IDLE;
                end
            end
        endcase
    end

    // All decisions take effect at the rising access clock edge.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cur_ff <= '{state: dram_arb_pkg::ST_IDLE, grant: dram_arb_pkg::GRANT_RST, start_cnt: 2'h0,
                        strobes: '0, ref_sync: '0, ref_seen: 1'b0, ref_active: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign second_port_grant = cur_ff.grant;
    assign second_port_early_ack = cur_ff.strobes.early_ack;
    assign row_strobe = cur_ff.strobes.row_strobe;
    assign col_strobe = cur_ff.strobes.col_strobe;
    assign refresh_grant = cur_ff.ref_active;
    // First port waits while it is not granted or refresh holds the array.
    assign first_port_wait = first_req & (cur_ff.grant | cur_ff.ref_active);

    // Refresh and lock cases are the ones that later edits break most easily.
    a_grant_stable: assert property (@(posedge clk_sys) disable iff (!rstn)
        first_port.lock |=> $stable(second_port_grant))
        else $error("grant moved while locked");
    a_grant_switch: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(second_port_grant) |-> $past(second_port_request) && !$past(first_req) && !$past(first_port.lock))
        else $error("grant switched without cause");
    a_grant_return: assert property (@(posedge clk_sys) disable iff (!rstn)
        $fell(second_port_grant) |-> $past(first_req) && !$past(second_port_request) && !$past(first_port.lock))
        else $error("grant returned without cause");
    a_grant_idle: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!first_req && !second_port_request) |=> $stable(second_port_grant))
        else $error("grant moved with no request");
    a_ack_row: assert property (@(posedge clk_sys) disable iff (!rstn)
        second_port_early_ack == row_strobe)
        else $error("early ack differs from row strobe");
    a_ack_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
        (second_port_early_ack && second_port_request) |=> second_port_early_ack)
        else $error("early ack dropped during request");
    a_row_release: assert property (@(posedge clk_sys) disable iff (!rstn)
        (row_strobe && !second_port_request) |=> !row_strobe)
        else $error("row strobe held after release");
    a_granted_start: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cur_ff.state == dram_arb_pkg::ST_IDLE && second_port_grant && second_port_request && !precharge_wait
         && !refresh_busy && !refresh_grant && !ref_level) |=> row_strobe)
        else $error("granted access did not start");
    a_col_extend: assert property (@(posedge clk_sys) disable iff (!rstn)
        (row_strobe && !second_port_request && col_hold) |=> (col_strobe && !row_strobe))
        else $error("column strobe not extended");
    a_col_release: assert property (@(posedge clk_sys) disable iff (!rstn)
        (col_strobe && !row_strobe && !col_hold) |=> !col_strobe)
        else $error("column strobe held after enables dropped");
    a_grant_lead: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(row_strobe) |-> second_port_grant && $past(second_port_grant))
        else $error("row strobe without prior grant");
    a_row_needs_grant: assert property (@(posedge clk_sys) disable iff (!rstn)
        row_strobe |-> second_port_grant)
        else $error("row strobe without grant");
    a_first_wait: assert property (@(posedge clk_sys) disable iff (!rstn)
        (first_req && second_port_grant) |-> first_port_wait)
        else $error("first port not waited");
    a_start_bound: assert property (@(posedge clk_sys) disable iff (!rstn)
        ($rose(second_port_grant) && !first_req && !precharge_wait && second_port_request)
        |-> ##[0:2] (row_strobe || !second_port_request || first_req || precharge_wait))
        else $error("access start late");
    a_start_early: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(second_port_grant) |-> !row_strobe)
        else $error("access started with grant");
    a_wait_row: assert property (@(posedge clk_sys) disable iff (!rstn)
        (cur_ff.state == dram_arb_pkg::ST_WAIT && (precharge_wait || first_req)) |=> !row_strobe)
        else $error("access started during precharge or first request");
    a_refresh_take: assert property (@(posedge clk_sys) disable iff (!rstn)
        (ref_level && cur_ff.state == dram_arb_pkg::ST_IDLE) |=> refresh_grant)
        else $error("refresh demand not taken");
    a_refresh_excl: assert property (@(posedge clk_sys) disable iff (!rstn)
        refresh_grant |-> !row_strobe)
        else $error("row strobe during refresh");
    a_refresh_first: assert property (@(posedge clk_sys) disable iff (!rstn)
        ((ref_level || refresh_grant) && cur_ff.state == dram_arb_pkg::ST_IDLE) |=> !row_strobe)
        else $error("access started ahead of refresh");

endmodule // dram_dual_port_arbiter

// ---- verif/cpu_b_model.sv ----
// Model of the second CPU, which drives the request of the second port.
`timescale 1ns/1ns
module cpu_b_model (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic rstn,
    // Command from the bench.
    input wire logic go,
    input wire logic [3:0] hold_cycles,
    // Answer from the arbiter.
    input wire logic second_port_early_ack,
    // Request with the address decode folded in, and model status.
    output logic second_port_request,
    output logic busy
);
    int n;
    initial begin
        second_port_request = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk_sys);
            if (go === 1'b1 && rstn === 1'b1) begin
                // Busy rises at the edge itself, so the bench looking one unit later cannot miss it.
                busy = 1'b1;
                #1;
                second_port_request = 1'b1;
                n = 0;
                // The request is held for hold_cycles+1 acknowledged edges, so a zero hold drops it at the first acknowledge.
                for (int k = 0; k < 200 && n <= hold_cycles; k++) begin
                    @(posedge clk_sys);
                    if (second_port_early_ack === 1'b1) n++;
                end
                #1;
                second_port_request = 1'b0;
                busy = 1'b0;
            end
        end
    end
endmodule // cpu_b_model

// ---- verif/dram_dual_port_arbiter_tb.sv ----
// Testbench of the dual-port DRAM arbiter.
`timescale 1ns/1ns
module dram_dual_port_arbiter_tb;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    dram_arb_pkg::first_port_t fp = '0;
    logic refresh_demand = 1'b0, refresh_busy = 1'b0, cen = 1'b0, cas_extend_cfg = 1'b0, cfg_low = 1'b0;
    logic go = 1'b0, row_seen = 1'b0, pwait = 1'b0;
    logic [3:0] hold_cycles = 4'h0;
    logic req, grant, ack, row, col, fwait, rgrant, busy;
    int fail_count = 0, compares = 0, cnt = 0;
    int notes[$];
    always #4 clk_sys = ~clk_sys;
    dram_dual_port_arbiter i_dram_dual_port_arbiter (.clk_sys(clk_sys), .rstn(rstn), .first_port(fp),
        .second_port_request(req), .refresh_demand(refresh_demand), .refresh_busy(refresh_busy),
        .precharge_wait(pwait), .column_enable_first(cen), .column_enable_n(cen), .cas_extend_cfg(cas_extend_cfg),
        .grant_delay_cfg_low(cfg_low), .grant_delay_cfg_high(1'b0), .second_port_grant(grant),
        .second_port_early_ack(ack), .row_strobe(row), .col_strobe(col), .first_port_wait(fwait),
        .refresh_grant(rgrant));
    cpu_b_model i_cpu_b_model (.clk_sys(clk_sys), .rstn(rstn), .go(go), .hold_cycles(hold_cycles),
        .second_port_early_ack(ack), .second_port_request(req), .busy(busy));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // Edges counted from the first edge where the second port could be taken.
    always @(posedge clk_sys) cnt = (req === 1'b1 && fp.chip_select === 1'b0 && rgrant === 1'b0) ? cnt + 1 : 0;
    always @(negedge clk_sys) begin
        if (row === 1'b1 && row_seen === 1'b0) begin
            if (notes.size() == 0) check(8'h1, 8'h0);
            else check(8'(cnt), 8'(notes.pop_front()));
            check(ack, 8'h1);
            check(grant, 8'(dram_arb_pkg::GRANT_SECOND));
        end
        row_seen = row;
    end
    task automatic first_use(input logic [3:0] bits, input logic exp_wait);
        fp = bits;
        #1;
        check(fwait, exp_wait);
        step(2);
        fp = 4'h0;
        step(1);
        check(grant, 8'(dram_arb_pkg::GRANT_FIRST));
    endtask
    // Blocked or precharge-delayed accesses hold the start back six edges; a first-port block restarts the count.
    task automatic access(input int exp, input logic ext, input logic [3:0] blk, input logic pw, input int t);
        int i;
        notes.push_back(exp);
        hold_cycles = 4'($urandom_range(7, 0));
        go = 1'b1;
        step(1);
        go = 1'b0;
        if (blk != 4'h0 || pw) begin
            fp = blk;
            pwait = pw;
            step(6);
            check(grant, 8'(pw ? dram_arb_pkg::GRANT_SECOND : dram_arb_pkg::GRANT_FIRST));
            check(row, 8'h0);
            fp = 4'h0;
            pwait = 1'b0;
        end
        for (i = 0; i < 100 && busy !== 1'b0; i++) begin
            @(posedge clk_sys);
            #2;
        end
        if (i == 100) begin
            fail_count++;
            close_out();
        end
        step(1);
        check(row, 8'h0);
        check(ack, 8'h0);
        check(col, 8'(ext));
        cen = 1'b0;
        step(1);
        check(col, 8'h0);
        $display("test %0d done", t);
    endtask
    initial begin
        int i;
        void'($urandom(32'ha8de));
        repeat (8) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        step(1);
        first_use(4'ha, 1'b0);
        access(7, 1'b0, 4'h0, 1'b1, 1);
        access(1, 1'b0, 4'h0, 1'b0, 2);
        cfg_low = 1'b1;
        first_use(4'hc, 1'b1);
        access(3, 1'b0, 4'h0, 1'b0, 3);
        cfg_low = 1'b0;
        cas_extend_cfg = 1'b1;
        cen = 1'b1;
        access(1, 1'b1, 4'h0, 1'b0, 4);
        cas_extend_cfg = 1'b0;
        first_use(4'ha, 1'b1);
        access(2, 1'b0, 4'hb, 1'b0, 5);
        first_use(4'ha, 1'b1);
        access(2, 1'b0, 4'hd, 1'b0, 6);
        fp = 4'h1;
        refresh_demand = 1'b1;
        refresh_busy = 1'b1;
        for (i = 0; i < 10 && rgrant !== 1'b1; i++) step(1);
        check(rgrant, 8'h1);
        refresh_demand = 1'b0;
        refresh_busy = 1'b0;
        fp = 4'h0;
        step(6);
        check(rgrant, 8'h0);
        check(8'(notes.size()), 8'h0);
        $display("test 7 done");
        close_out();
    end
endmodule // dram_dual_port_arbiter_tb
